// [rtl/qb_port_pkg.sv]
// Package for the quasi-bidirectional port: timing slots, pin states, carriers
`default_nettype none
package qb_port_pkg;
    localparam int          PORT_WIDTH     = 8;
    localparam logic [7:0]  LATCH_RESET    = 8'hFF;
    localparam int          OSC_PERIOD_NS  = 40;
    localparam int          STRONG_PU_NS   = 80;
    // Strong pull-up lasts two oscillator periods
    localparam int          STRONG_PU_CYC  = (STRONG_PU_NS + OSC_PERIOD_NS - 1) / OSC_PERIOD_NS;
    localparam logic [2:0]  SLOT_LAST      = 3'h5;
    localparam logic [2:0]  SLOT_S1        = 3'h0;
    localparam logic [2:0]  SLOT_S5        = 3'h4;
    localparam logic [2:0]  SLOT_S6        = 3'h5;
    localparam logic [1:0]  STRONG_CNT_MAX = 2'(STRONG_PU_CYC);

    // Pin driver states, Gray along rise path
    typedef enum logic [2:0] {
        ST_INPUT_LOW   = 3'h0,
        ST_INPUT_HIGH  = 3'h1,
        ST_FORCED_HIGH = 3'h3,
        ST_OUTPUT_LOW  = 3'h2,
        ST_ANALOG_OFF  = 3'h6
    } pin_state_type;

    // CPU access request for one cycle
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic       rmw;
        logic [7:0] wdata;
    } cpu_req_type;

    // Per-pin driver enables
    typedef struct packed {
        logic strong_pullup;
        logic weak_pullup;
        logic level_pullup;
        logic pulldown_driver;
    } drive_type;
endpackage
`default_nettype wire

// [rtl/quasi_bidir_port_control.sv]
// Eight-bit quasi-bidirectional port latch, driver sequencing and pin sampling
//
// Operation
// - Latch zero to one: all three pull-ups on for two cycles, then steady high.
// - Rewriting one over one leaves drivers unchanged, no strong pulse.
// - Latch zero: output low, only pulldown driver on.
// - Latch one: weak pull-up on; level pull-up follows pin high level.
// - Analog select switches off all four drivers regardless of latch.
// - Reset sets every latch bit to one.
// - Latch written in S6P2; value reaches pin at next S3.
// - Output buffers sample latch only in S1P1, hold it for the rest of the machine cycle.
// - Pin reads sample pin level during state five.
// - Pin sampled once per machine cycle; edge when sample differs.
// - Read-modify-write accesses read the latch, not the pin.
// - Other port reads return sampled pin levels.
// - Bit operations read whole latch byte, write whole byte back.
// - Strong pulse lasts two oscillator periods, slots S3 and S4.
// - Alternate functions pass only while latch bit is one.
`default_nettype none
module quasi_bidir_port_control (
    // Clock and reset
    input  wire logic                    mclk,
    input  wire logic                    rst_n,
    // CPU side
    input  wire qb_port_pkg::cpu_req_type cpu_req,
    output var  logic [7:0]              rdata,
    output var  logic                    rvalid,
    output var  logic [7:0]              latch_q,
    // Alternate functions and analog select
    input  wire logic [7:0]              alt_out,
    input  wire logic [7:0]              analog_select_bits,
    output var  logic [7:0]              alt_in,
    output var  logic [7:0]              edge_flag,
    // Pins
    input  wire logic [7:0]              pin_in,
    output var  qb_port_pkg::drive_type [7:0] drive,
    output var  logic [2:0]              slot
);
    logic [2:0] slot_reg;
    logic [7:0] pin_meta_reg;
    logic [7:0] pin_sync_reg;
    logic [7:0] latch_reg;
    logic [7:0] latch_next;
    logic [7:0] buf_reg;
    logic [7:0] buf_prev_reg;
    logic [7:0] sample_reg;
    logic       wr_pend_reg;
    logic [7:0] wr_data_reg;
    logic [7:0] ana_meta_reg;
    logic [7:0] ana_sync_reg;

    // Six oscillator periods per machine cycle
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            slot_reg <= qb_port_pkg::SLOT_S1;
        end else if (slot_reg == qb_port_pkg::SLOT_LAST) begin
            slot_reg <= qb_port_pkg::SLOT_S1;
        end else begin
            slot_reg <= slot_reg + 3'h1;
        end
    end
    assign slot = slot_reg;

    // Pin and analog select synchronisers
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta_reg <= 8'hFF;
            pin_sync_reg <= 8'hFF;
            ana_meta_reg <= 8'h00;
            ana_sync_reg <= 8'h00;
        end else begin
            pin_meta_reg <= pin_in;
            pin_sync_reg <= pin_meta_reg;
            ana_meta_reg <= analog_select_bits;
            ana_sync_reg <= ana_meta_reg;
        end
    end

    // whole byte merged
    // Bit operations already come merged as a full byte from the CPU
    always_comb begin
        latch_next = latch_reg;
        if (wr_pend_reg && slot_reg == qb_port_pkg::SLOT_S6) begin
            latch_next = wr_data_reg;
        end
    end

    // Hold a write until the final slot of the cycle
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wr_pend_reg <= 1'b0;
            wr_data_reg <= 8'h00;
        end else if (cpu_req.wr) begin
            wr_pend_reg <= 1'b1;
            wr_data_reg <= cpu_req.wdata;
        end else if (slot_reg == qb_port_pkg::SLOT_S6) begin
            wr_pend_reg <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            latch_reg <= qb_port_pkg::LATCH_RESET;
        end else begin
            latch_reg <= latch_next;
        end
    end
    assign latch_q = latch_reg;

    // buffer samples at S1P1 only
    // Buffer copy lags latch one slot; the registered drivers put the change on the pin two slots after the latch
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            buf_reg      <= qb_port_pkg::LATCH_RESET;
            buf_prev_reg <= qb_port_pkg::LATCH_RESET;
        end else if (slot_reg == qb_port_pkg::SLOT_S1) begin
            buf_prev_reg <= buf_reg;
            buf_reg      <= latch_reg;
        end
    end

    // Per-bit driver sequencing
    generate
        for (genvar i = 0; i < qb_port_pkg::PORT_WIDTH; i++) begin : g_bit
            qb_port_pkg::pin_state_type st;
            always_comb begin
                if (ana_sync_reg[i]) begin
                    st = qb_port_pkg::ST_ANALOG_OFF;
                end else if (!buf_reg[i]) begin
                    st = qb_port_pkg::ST_OUTPUT_LOW;
                end else if (!buf_prev_reg[i] &&
                             (slot_reg == 3'h1 || slot_reg == 3'h2)) begin
                    st = qb_port_pkg::ST_FORCED_HIGH;
                end else if (pin_sync_reg[i]) begin
                    st = qb_port_pkg::ST_INPUT_HIGH;
                end else begin
                    st = qb_port_pkg::ST_INPUT_LOW;
                end
            end
            // Registered driver outputs
            always_ff @(posedge mclk or negedge rst_n) begin
                if (!rst_n) begin
                    drive[i] <= '{1'b0, 1'b1, 1'b0, 1'b0};
                end else begin
                    drive[i].strong_pullup   <= (st == qb_port_pkg::ST_FORCED_HIGH);
                    drive[i].weak_pullup     <= (st == qb_port_pkg::ST_FORCED_HIGH) ||
                                                (st == qb_port_pkg::ST_INPUT_HIGH) ||
                                                (st == qb_port_pkg::ST_INPUT_LOW);
                    drive[i].level_pullup    <= (st == qb_port_pkg::ST_FORCED_HIGH) ||
                                                (st == qb_port_pkg::ST_INPUT_HIGH);
                    drive[i].pulldown_driver <= (st == qb_port_pkg::ST_OUTPUT_LOW) ||
                                                (st != qb_port_pkg::ST_ANALOG_OFF &&
                                                 buf_reg[i] && !alt_out[i]);
                end
            end
        end
    endgenerate

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sample_reg      <= 8'hFF;
            edge_flag       <= 8'h00;
            alt_in          <= 8'h00;
        end else if (slot_reg == qb_port_pkg::SLOT_S5) begin
            sample_reg      <= pin_sync_reg;
            edge_flag       <= pin_sync_reg ^ sample_reg;
            // alternate input only when latch one
            alt_in          <= pin_sync_reg & latch_reg;
        end else begin
            edge_flag       <= 8'h00;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rdata  <= 8'h00;
            rvalid <= 1'b0;
        end else begin
            rvalid <= cpu_req.rd;
            if (cpu_req.rd) begin
                rdata <= cpu_req.rmw ? latch_reg : sample_reg;
            end
        end
    end

    // Strong pulse only after a zero-to-one change
    property p_rise_only;
        @(posedge mclk) disable iff (!rst_n)
        drive[0].strong_pullup |-> ($past(buf_prev_reg[0]) == 1'b0);
    endproperty
    a_rise_only: assert property (p_rise_only) else $error("strong pull-up without rise");

    property p_low_state;
        @(posedge mclk) disable iff (!rst_n)
        (!buf_reg[0] && !ana_sync_reg[0]) |=> (drive[0].pulldown_driver && !drive[0].weak_pullup);
    endproperty
    a_low_state: assert property (p_low_state) else $error("output low wrong");

    property p_analog_off;
        @(posedge mclk) disable iff (!rst_n)
        ana_sync_reg[0] |=> (drive[0] == 4'h0);
    endproperty
    a_analog_off: assert property (p_analog_off) else $error("analog drivers on");

    property p_rmw_latch;
        @(posedge mclk) disable iff (!rst_n)
        (cpu_req.rd && cpu_req.rmw) |=> (rdata == $past(latch_reg));
    endproperty
    a_rmw_latch: assert property (p_rmw_latch) else $error("rmw read not latch");

    property p_pin_read;
        @(posedge mclk) disable iff (!rst_n)
        (cpu_req.rd && !cpu_req.rmw) |=> (rdata == $past(sample_reg));
    endproperty
    a_pin_read: assert property (p_pin_read) else $error("pin read not sample");

    property p_latch_slot;
        @(posedge mclk) disable iff (!rst_n)
        (latch_reg != $past(latch_reg)) |-> ($past(slot_reg) == qb_port_pkg::SLOT_S6);
    endproperty
    a_latch_slot: assert property (p_latch_slot) else $error("latch changed off slot");

    property p_buf_slot;
        @(posedge mclk) disable iff (!rst_n)
        (buf_reg != $past(buf_reg)) |-> ($past(slot_reg) == qb_port_pkg::SLOT_S1);
    endproperty
    a_buf_slot: assert property (p_buf_slot) else $error("buffer sampled off phase");

    property p_edge_slot;
        @(posedge mclk) disable iff (!rst_n)
        (edge_flag != 8'h00) |-> ($past(slot_reg) == qb_port_pkg::SLOT_S5);
    endproperty
    a_edge_slot: assert property (p_edge_slot) else $error("edge off sample slot");
endmodule
`default_nettype wire

// [testbench/pin_load_model.sv]
// External circuitry that loads the port pins and resolves their levels
`default_nettype none
module pin_load_model (
    // Clock
    input  wire logic                         mclk,
    // Port drivers and external pull-downs
    input  wire qb_port_pkg::drive_type [7:0] drive,
    input  wire logic [7:0]                   ext_low,
    // Resolved pin levels
    output var  logic [7:0]                   pin_level
);
    timeunit 1ns;
    timeprecision 1ns;
    logic float_reg = 1'b0;
    // Released pins toggle so a stale level is never mistaken for a drive
    always @(posedge mclk) begin
        float_reg <= ~float_reg;
    end
    // Pin resolution: pulldown or outside sink wins over any pull-up
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (drive[i].pulldown_driver || ext_low[i]) begin
                pin_level[i] = 1'b0;
            end else if (drive[i].strong_pullup || drive[i].weak_pullup) begin
                pin_level[i] = 1'b1;
            end else begin
                pin_level[i] = float_reg;
            end
        end
    end
endmodule
`default_nettype wire

// [testbench/tb_quasi_bidir_port_control.sv]
// Self-checking bench for the quasi-bidirectional port control block
`default_nettype none
module tb_quasi_bidir_port_control;
    timeunit 1ns;
    timeprecision 1ns;
    logic                      mclk = 1'b0;
    logic                      rst_n = 1'b0;
    qb_port_pkg::cpu_req_type  cpu_req = '0;
    logic [7:0]                rdata, latch_q, alt_in, edge_flag, pin_in, d;
    logic [7:0]                ext_low = 8'h00;
    logic [7:0]                analog_select_bits = 8'h00;
    logic [7:0]                alt_out = 8'hFF;
    logic                      rvalid;
    logic [2:0]                slot;
    qb_port_pkg::drive_type [7:0] drive;
    logic [3:0]                seen;
    int                        n_mismatch = 0, comparisons = 0, n;

    // Free-running 25 MHz clock
    always #20 mclk = ~mclk;

    quasi_bidir_port_control quasi_bidir_port_control_inst (.mclk(mclk), .rst_n(rst_n),
        .cpu_req(cpu_req), .rdata(rdata), .rvalid(rvalid), .latch_q(latch_q),
        .alt_out(alt_out), .analog_select_bits(analog_select_bits), .alt_in(alt_in),
        .edge_flag(edge_flag), .pin_in(pin_in), .drive(drive), .slot(slot));
    pin_load_model pin_load_model_inst (.mclk(mclk), .drive(drive), .ext_low(ext_low),
        .pin_level(pin_in));

    // Counts and verdict, then stop
    task automatic end_sim;
        $display("Mismatches %0d, comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic step(input int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask
    // Write a byte; optionally check the slot at which the latch takes it
    task automatic wr_latch(input logic [7:0] v, input bit chk);
        int k;
        @(posedge mclk) cpu_req <= {1'b1, 1'b0, 1'b0, v};
        @(posedge mclk) cpu_req <= '0;
        #1;
        for (k = 0; k < 8 && latch_q !== v; k++) step(1);
        if (latch_q !== v) begin n_mismatch++; end_sim(); end
        if (chk) check8({5'h00, slot}, {5'h00, qb_port_pkg::SLOT_S1});
    endtask
    task automatic rd_port(input logic rmw, output logic [7:0] v);
        int k;
        @(posedge mclk) cpu_req <= {1'b0, 1'b1, rmw, 8'h00};
        @(posedge mclk) cpu_req <= '0;
        #1;
        for (k = 0; k < 3 && rvalid !== 1'b1; k++) step(1);
        if (rvalid !== 1'b1) begin n_mismatch++; end_sim(); end
        v = rdata;
    endtask
    // Cycles with the strong pull-up on bit 0 over a window
    task automatic count_strong(input int win, output int cnt, output logic [3:0] s);
        cnt = 0;
        repeat (win) begin
            step(1);
            if (drive[0].strong_pullup === 1'b1) begin cnt++; s = drive[0]; end
        end
    endtask

    task automatic t_reset;
        repeat (4) @(posedge mclk);
        #1;
        check8(latch_q, qb_port_pkg::LATCH_RESET);
        check8({4'h0, drive[0]}, 8'h04);
        @(posedge mclk) rst_n <= 1'b1;
        step(14);
        check8({4'h0, drive[0]}, 8'h06);
    endtask
    task automatic t_rise;
        wr_latch(8'h00, 1'b1);
        step(3);
        check8({4'h0, drive[0]}, 8'h01);
        wr_latch(8'hFF, 1'b1);
        count_strong(8, n, seen);
        check8(8'(n), 8'(qb_port_pkg::STRONG_PU_CYC));
        check8({4'h0, seen}, 8'h0E);
        check8({4'h0, drive[0]}, 8'h06);
        wr_latch(8'hFF, 1'b0);
        count_strong(12, n, seen);
        check8(8'(n), 8'h00);
    endtask
    task automatic t_level;
        ext_low <= 8'h08;
        step(14);
        check8({4'h0, drive[3]}, 8'h04);
        ext_low <= 8'h00;
        step(14);
        check8({4'h0, drive[3]}, 8'h06);
    endtask
    task automatic t_reads;
        wr_latch(8'h0F, 1'b1);
        ext_low <= 8'h01;
        step(14);
        rd_port(1'b1, d);
        check8(d, 8'h0F);
        rd_port(1'b0, d);
        check8(d, 8'h0E);
        check8(alt_in, 8'h0E);
        rd_port(1'b1, d);
        wr_latch(d | 8'h80, 1'b0);
        rd_port(1'b1, d);
        check8(d, 8'h8F);
        step(14);
        rd_port(1'b0, d);
        check8(d, 8'h8E);
        ext_low <= 8'h00;
        step(14);
    endtask
    // Each level held two machine cycles, above the minimum
    task automatic t_edge;
        repeat (2) begin
            ext_low[7] <= ~ext_low[7];
            n = 0;
            repeat (12) begin
                step(1);
                if (edge_flag[7] === 1'b1) n++;
            end
            check8(8'(n), 8'h01);
        end
    endtask
    // Alternate output low pulls a latch-one pin down; a pin whose alternate output stays high keeps its pulldown off
    task automatic t_alt;
        @(posedge mclk) alt_out <= 8'hFB;
        step(4);
        check8({7'h00, drive[2].pulldown_driver}, 8'h01);
        check8({7'h00, drive[3].pulldown_driver}, 8'h00);
        @(posedge mclk) alt_out <= 8'hFF;
        step(14);
        check8({4'h0, drive[2]}, 8'h06);
    endtask
    task automatic t_analog;
        @(posedge mclk) analog_select_bits <= 8'h01;
        step(8);
        check8({4'h0, drive[0]}, 8'h00);
        check8({4'h0, drive[1]}, 8'h06);
        @(posedge mclk) analog_select_bits <= 8'h00;
        step(14);
        check8({4'h0, drive[0]}, 8'h06);
    endtask

    initial begin
        t_reset();
        t_rise();
        t_level();
        t_reads();
        t_alt();
        t_edge();
        t_analog();
        end_sim();
    end
endmodule
`default_nettype wire
